// ### design/ulc_pkg.sv
// ulc_pkg: constants and carriers for the usb link control and address block
// assumes a 32-bit avalon-mm slave with word-aligned registers
package ulc_pkg;
	localparam logic [3:0] ULC_OFS_CTL    = 4'h0;
	localparam logic [3:0] ULC_OFS_ADDR   = 4'h4;
	localparam logic [3:0] ULC_OFS_TOKEN  = 4'h8;
	localparam logic [3:0] ULC_OFS_STATUS = 4'hc;
	localparam int CTL_LIVE_J_STATE  = 7;
	localparam int CTL_SE0     = 6;
	localparam int CTL_SUSP    = 5;
	localparam int CTL_RESET   = 4;
	localparam int CTL_HOST    = 3;
	localparam int CTL_RESUME  = 2;
	localparam int CTL_PINGPONG_BANK_CLEAR  = 1;
	localparam int CTL_EN      = 0;
	localparam int ADDR_LS     = 7;
	localparam logic [7:0] ULC_CTL_RST  = 8'h00;
	localparam logic [7:0] ULC_ADDR_RST = 8'h00;
	localparam logic [3:0] PID_OUT   = 4'h1;
	localparam logic [3:0] PID_IN    = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hd;
	localparam logic [31:0] ULC_UNMAPPED = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		ULC_TT_NONE  = 2'b00,
		ULC_TT_OUT   = 2'b01,
		ULC_TT_IN    = 2'b10,
		ULC_TT_SETUP = 2'b11
	} ulc_tok_kind_t;

	typedef enum logic [1:0]
	{
		ULC_ST_IDLE = 2'b00,
		ULC_ST_PRE  = 2'b01,
		ULC_ST_BUSY = 2'b10
	} ulc_state_t;

	// command handed to the serial engine for a host token
	typedef struct packed
	{
		ulc_tok_kind_t kind;
		logic [3:0]    endpt;
		logic [6:0]    dev_addr;
		logic          slow;
	} ulc_token_cmd_t;

	// live line state and engine events from the serial engine
	typedef struct packed
	{
		logic j_raw;
		logic se0;
		logic setup_rx;
		logic bus_reset_rx;
		logic token_done;
		logic preamble_done;
	} ulc_sie_evt_t;
endpackage : ulc_pkg

// ### design/ulc_link_ctrl.sv
// ulc_link_ctrl: control and bus address registers of a usb fs/ls controller
// assumes an avalon-mm master on sys_clk and a serial engine that reports
// line state and events synchronously on the same clock
module ulc_link_ctrl
	import ulc_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           rst_n,
	input  wire logic [3:0]     avs_address,
	input  wire logic           avs_read,
	input  wire logic           avs_write,
	input  wire logic [31:0]    avs_writedata,
	input  wire logic [3:0]     avs_byteenable,
	output logic [31:0]         avs_readdata,
	output logic                avs_waitrequest,
	input  wire ulc_sie_evt_t   sie_evt,
	output ulc_token_cmd_t      token_cmd_q,
	output logic                token_start_q,
	output logic                preamble_req_q,
	output logic                drive_bus_reset,
	output logic                drive_resume,
	output logic                ls_eop_pulse_q,
	output logic                pingpong_bank_clear_q,
	output logic                engine_reset_q,
	output logic                sof_enable,
	output logic                packet_xfer_enable,
	output logic                addr_match_enable,
	output logic [6:0]          own_address
);

	logic [7:0]      ctl_q;
	logic [7:0]      addr_q;
	logic            flag5_q;
	logic [7:0]      tok_q;
	ulc_state_t      state_q;
	logic            ack_q;
	logic            req;
	logic            wr_ctl;
	logic            wr_addr;
	logic            wr_tok;
	logic [7:0]      wdat;
	logic            host;
	logic            live_j;

	function automatic ulc_tok_kind_t pid_kind(input logic [3:0] pid);
		case (pid)
			PID_OUT:   pid_kind = ULC_TT_OUT;
			PID_IN:    pid_kind = ULC_TT_IN;
			PID_SETUP: pid_kind = ULC_TT_SETUP;
			default:   pid_kind = ULC_TT_NONE;
		endcase
	endfunction : pid_kind

	// one wait cycle per access: request taken at the edge where ack_q is 1
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wdat            = avs_writedata[7:0];
	assign wr_ctl  = avs_write & ack_q & avs_byteenable[0]
		& (avs_address == ULC_OFS_CTL);
	assign wr_addr = avs_write & ack_q & avs_byteenable[0]
		& (avs_address == ULC_OFS_ADDR);
	assign wr_tok  = avs_write & ack_q & avs_byteenable[0]
		& (avs_address == ULC_OFS_TOKEN);
	assign host    = ctl_q[CTL_HOST];
	// j is d+ high at full speed, d- high at low speed
	assign live_j  = sie_evt.j_raw ^ addr_q[ADDR_LS];

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			avs_readdata <= ULC_UNMAPPED;
		else if (avs_read & ~ack_q)
		begin
			case (avs_address)
				ULC_OFS_CTL:    avs_readdata <= {24'h000000, live_j,
					sie_evt.se0, flag5_q, ctl_q[4:0]};
				ULC_OFS_ADDR:   avs_readdata <= {24'h000000, addr_q};
				ULC_OFS_TOKEN:  avs_readdata <= {24'h000000, tok_q};
				ULC_OFS_STATUS: avs_readdata <= {30'h00000000,
					state_q};
				default:        avs_readdata <= ULC_UNMAPPED;
			endcase
		end
	end

	// bits 7 and 6 are never stored, so writes to them vanish
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ctl_q <= ULC_CTL_RST;
		else if (wr_ctl)
			ctl_q <= {3'b000, wdat[4:0]};
	end

	// bit 5: hardware set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			flag5_q <= 1'b0;
		else if (host)
			flag5_q <= (state_q != ULC_ST_IDLE) | wr_tok;
		else if (sie_evt.setup_rx & ctl_q[CTL_EN])
			flag5_q <= 1'b1;
		else if (wr_ctl & ~wdat[CTL_SUSP])
			flag5_q <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			addr_q <= ULC_ADDR_RST;
		else if (~host & sie_evt.bus_reset_rx)
			addr_q <= ULC_ADDR_RST;
		else if (wr_addr)
			addr_q <= wdat;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			tok_q <= 8'h00;
		else if (wr_tok)
			tok_q <= wdat;
	end

	// a token written while busy is dropped; software must poll first
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_q        <= ULC_ST_IDLE;
			token_start_q  <= 1'b0;
			preamble_req_q <= 1'b0;
			token_cmd_q    <= '0;
		end
		else
		begin
			token_start_q  <= 1'b0;
			preamble_req_q <= 1'b0;
			case (state_q)
				ULC_ST_IDLE:
				begin
					if (wr_tok & host & ctl_q[CTL_EN]
						& (pid_kind(wdat[7:4]) != ULC_TT_NONE))
					begin
						token_cmd_q.kind     <= pid_kind(wdat[7:4]);
						token_cmd_q.endpt    <= wdat[3:0];
						token_cmd_q.dev_addr <= addr_q[6:0];
						token_cmd_q.slow     <= addr_q[ADDR_LS];
						if (addr_q[ADDR_LS])
						begin
							preamble_req_q <= 1'b1;
							state_q        <= ULC_ST_PRE;
						end
						else
						begin
							token_start_q <= 1'b1;
							state_q       <= ULC_ST_BUSY;
						end
					end
				end
				ULC_ST_PRE:
				begin
					if (sie_evt.preamble_done)
					begin
						token_start_q <= 1'b1;
						state_q       <= ULC_ST_BUSY;
					end
				end
				ULC_ST_BUSY:
				begin
					if (sie_evt.token_done)
						state_q <= ULC_ST_IDLE;
				end
				default: state_q <= ULC_ST_IDLE;
			endcase
			if (!host | !ctl_q[CTL_EN])
				state_q <= ULC_ST_IDLE;
		end
	end

	// ping-pong clear and engine reset: one-cycle pulses
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			pingpong_bank_clear_q <= 1'b0;
			engine_reset_q        <= 1'b0;
		end
		else
		begin
			pingpong_bank_clear_q <= wr_ctl & (wdat[CTL_PINGPONG_BANK_CLEAR]
				| (wdat[CTL_EN] & ~ctl_q[CTL_EN]));
			engine_reset_q <= wr_ctl & wdat[CTL_EN]
				& ~ctl_q[CTL_EN];
		end
	end

	// falling edge of resume in host role adds a low-speed eop
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ls_eop_pulse_q <= 1'b0;
		else
			ls_eop_pulse_q <= host & ctl_q[CTL_RESUME]
				& wr_ctl & ~wdat[CTL_RESUME];
	end

	assign drive_bus_reset    = host & ctl_q[CTL_RESET];
	assign drive_resume       = ctl_q[CTL_RESUME];
	assign sof_enable         = host & ctl_q[CTL_EN];
	assign packet_xfer_enable = ctl_q[CTL_EN] & (host | ~flag5_q);
	assign addr_match_enable  = ~host & ctl_q[CTL_EN];
	assign own_address        = addr_q[6:0];

	a_reset_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		drive_bus_reset |-> ctl_q[CTL_HOST])
		else $error("bus reset driven outside host role");
	a_setup_suspend: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!host && ctl_q[CTL_EN] && sie_evt.setup_rx && !$past(host))
		|=> flag5_q)
		else $error("setup did not set suspend flag");
	a_suspend_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!host && flag5_q) |-> !packet_xfer_enable)
		else $error("packet traffic while suspended");
	a_busy_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(host && state_q != ULC_ST_IDLE && $past(host)) |=> flag5_q)
		else $error("busy flag low while token runs");
	a_addr_busreset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!host && sie_evt.bus_reset_rx) |=> addr_q == ULC_ADDR_RST)
		else $error("address not cleared by bus reset");
	a_pingpong_bank_clear_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_ctl && wdat[CTL_PINGPONG_BANK_CLEAR]) |=> pingpong_bank_clear_q ##1
		!pingpong_bank_clear_q || $past(wr_ctl))
		else $error("ping-pong clear missing");
	a_ls_preamble: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ULC_ST_IDLE && wr_tok && host && ctl_q[CTL_EN]
		&& addr_q[ADDR_LS] && pid_kind(wdat[7:4]) != ULC_TT_NONE)
		|=> preamble_req_q && !token_start_q)
		else $error("low-speed token without preamble");
	a_fs_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ULC_ST_IDLE && wr_tok && host && ctl_q[CTL_EN]
		&& !addr_q[ADDR_LS] && wdat[7:4] == PID_IN)
		|=> token_start_q && token_cmd_q.kind == ULC_TT_IN)
		else $error("in token not started");
	a_sof_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ctl_q[CTL_EN] |-> !sof_enable)
		else $error("sof while disabled");
	a_ls_eop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(host && ctl_q[CTL_RESUME] && wr_ctl && !wdat[CTL_RESUME])
		|=> ls_eop_pulse_q)
		else $error("no eop after resume");
	a_bus_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(req && !ack_q) |=> !avs_waitrequest || !req)
		else $error("waitrequest held too long");

	c_host_token: cover property (@(posedge sys_clk) disable iff (!rst_n)
		token_start_q);
	c_ls_token: cover property (@(posedge sys_clk) disable iff (!rst_n)
		preamble_req_q);
	c_setup_susp: cover property (@(posedge sys_clk) disable iff (!rst_n)
		!host && $rose(flag5_q));
	c_bus_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
		drive_bus_reset);

endmodule : ulc_link_ctrl

// ### verification/ulc_sie_model.sv
// ulc_sie_model: behavioural serial engine and bus lines beside the block
// assumes the block's pulses are synchronous to sys_clk
module ulc_sie_model
	import ulc_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         token_start_q,
	input  wire logic         preamble_req_q,
	input  wire logic [7:0]   tok_cycles,
	input  wire logic         j_line,
	input  wire logic         se0_line,
	input  wire logic         setup_seen,
	input  wire logic         reset_seen,
	output ulc_sie_evt_t      sie_evt
);
	logic [7:0] tok_left_q;
	logic [1:0] pre_left_q;
	logic       tok_done_q;
	logic       pre_done_q;

	// tok_cycles lets the bench make the far side prompt or slow
	always_ff @(posedge sys_clk)
	begin
		tok_done_q <= 1'b0;
		if (!rst_n)
			tok_left_q <= 8'h00;
		else if (token_start_q)
			tok_left_q <= tok_cycles;
		else if (tok_left_q != 8'h00)
		begin
			tok_left_q <= tok_left_q - 8'h01;
			tok_done_q <= (tok_left_q == 8'h01);
		end
	end

	// preamble takes a fixed short time before the low-speed token
	always_ff @(posedge sys_clk)
	begin
		pre_done_q <= 1'b0;
		if (!rst_n)
			pre_left_q <= 2'h0;
		else if (preamble_req_q)
			pre_left_q <= 2'h3;
		else if (pre_left_q != 2'h0)
		begin
			pre_left_q <= pre_left_q - 2'h1;
			pre_done_q <= (pre_left_q == 2'h1);
		end
	end

	assign sie_evt = {j_line, se0_line, setup_seen, reset_seen,
		tok_done_q, pre_done_q};
endmodule : ulc_sie_model

// ### verification/test_usb_link_control_and_address.sv
// test_usb_link_control_and_address: register and token bench
// assumes ulc_pkg, the design and ulc_sie_model are compiled first
module test_usb_link_control_and_address
	import ulc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic           sys_clk, rst_n, avs_read, avs_write;
	logic [3:0]     avs_address;
	logic [31:0]    avs_writedata, avs_readdata, rd;
	logic           avs_waitrequest, tok_st, pre_rq, eop, odd, ers;
	logic           bus_rst, resume, sof, xfer_en, match_en;
	logic [6:0]     own_addr;
	ulc_sie_evt_t   sie_evt;
	ulc_token_cmd_t tok_cmd, tok_seen;
	logic [7:0]     tcyc;
	logic           j_line, se0_line, setup_seen, reset_seen;
	logic [3:0]     pids [4] = '{4'h1, 4'h9, 4'hd, 4'h3};
	logic [1:0]     kinds [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	int             fail_count = 0;
	int             comparisons = 0;
	int             cyc = 0;
	int             n_tok = 0, n_pre = 0, n_eop = 0, n_odd = 0, n_ers = 0;

	ulc_link_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sie_evt(sie_evt),
		.token_cmd_q(tok_cmd), .token_start_q(tok_st),
		.preamble_req_q(pre_rq), .drive_bus_reset(bus_rst),
		.drive_resume(resume), .ls_eop_pulse_q(eop),
		.pingpong_bank_clear_q(odd), .engine_reset_q(ers),
		.sof_enable(sof), .packet_xfer_enable(xfer_en),
		.addr_match_enable(match_en), .own_address(own_addr));
	ulc_sie_model sie (.sys_clk(sys_clk), .rst_n(rst_n),
		.token_start_q(tok_st), .preamble_req_q(pre_rq),
		.tok_cycles(tcyc), .j_line(j_line), .se0_line(se0_line),
		.setup_seen(setup_seen), .reset_seen(reset_seen),
		.sie_evt(sie_evt));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// pulse counters; read by the sequence only after a few idle edges
	always @(posedge sys_clk)
	begin
		cyc++;
		if (tok_st === 1'b1)
		begin
			n_tok++;
			tok_seen = tok_cmd;
		end
		n_pre += int'(pre_rq === 1'b1);
		n_eop += int'(eop === 1'b1);
		n_odd += int'(odd === 1'b1);
		n_ers += int'(ers === 1'b1);
		if (cyc == 5000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic check_reg(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : check_reg

	task automatic check_bit(input string nm, input logic exp, input logic got);
		check_reg(nm, {31'h0, exp}, {31'h0, got});
	endtask : check_bit

	// values read right after an edge are the ones that edge sampled;
	// one idle edge after the release lets outputs settle before checks
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= !wr;
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic wait_idle();
		int n;
		n = 0;
		rd = 32'h20;
		while (rd[5] !== 1'b0 && n < 60)
		begin
			bus(0, ULC_OFS_CTL, 8'h00);
			n++;
		end
		check_bit("idle", 1'b0, rd[5]);
	endtask : wait_idle

	initial
	begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		tcyc = 8'd20;
		j_line = 1'b1;
		se0_line = 1'b0;
		setup_seen = 1'b0;
		reset_seen = 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(0, ULC_OFS_CTL, 8'h00);
		check_reg("ctl", 32'h80, rd);
		bus(0, 4'h2, 8'h00);
		check_reg("unmapped", ULC_UNMAPPED, rd);
		bus(1, ULC_OFS_CTL, 8'hc0);
		se0_line <= 1'b1;
		bus(1, ULC_OFS_ADDR, 8'h80);
		bus(0, ULC_OFS_CTL, 8'h00);
		check_reg("ctl", 32'h40, rd);
		bus(0, ULC_OFS_ADDR, 8'h00);
		check_reg("addr", 32'h80, rd);
		bus(1, ULC_OFS_CTL, 8'h15);
		repeat (3) @(posedge sys_clk);
		check_reg("odd", 32'h1, n_odd);
		check_reg("ers", 32'h1, n_ers);
		check_bit("busrst", 1'b0, bus_rst);
		check_bit("resume", 1'b1, resume);
		check_bit("match", 1'b1, match_en);
		bus(1, ULC_OFS_ADDR, 8'h33);
		check_reg("own", 32'h33, {25'h0, own_addr});
		bus(1, ULC_OFS_CTL, 8'h01);
		@(posedge sys_clk);
		setup_seen <= 1'b1;
		@(posedge sys_clk);
		setup_seen <= 1'b0;
		bus(0, ULC_OFS_CTL, 8'h00);
		check_reg("ctl", 32'he1, rd);
		check_bit("xfer", 1'b0, xfer_en);
		bus(1, ULC_OFS_CTL, 8'h01);
		bus(0, ULC_OFS_CTL, 8'h00);
		check_reg("ctl", 32'hc1, rd);
		check_bit("xfer", 1'b1, xfer_en);
		@(posedge sys_clk);
		reset_seen <= 1'b1;
		@(posedge sys_clk);
		reset_seen <= 1'b0;
		bus(0, ULC_OFS_ADDR, 8'h00);
		check_reg("addr", 32'h0, rd);
		bus(1, ULC_OFS_CTL, 8'h19);
		check_bit("busrst", 1'b1, bus_rst);
		check_bit("sof", 1'b1, sof);
		repeat (10) @(posedge sys_clk);
		bus(1, ULC_OFS_CTL, 8'h0d);
		check_bit("busrst", 1'b0, bus_rst);
		bus(1, ULC_OFS_CTL, 8'h09);
		bus(1, ULC_OFS_CTL, 8'h0b);
		repeat (3) @(posedge sys_clk);
		check_reg("eop", 32'h1, n_eop);
		check_reg("odd", 32'h2, n_odd);
		bus(1, ULC_OFS_ADDR, 8'h25);
		for (int i = 0; i < 4; i++)
		begin
			int k;
			k = n_tok;
			wait_idle();
			bus(1, ULC_OFS_TOKEN, {pids[i], 4'(i + 2)});
			repeat (3) @(posedge sys_clk);
			check_reg("starts", k + int'(kinds[i] != 2'h0), n_tok);
			if (kinds[i] != 2'h0)
			begin
				check_reg("cmd", {18'h0, kinds[i], 4'(i + 2), 8'h4a},
					{18'h0, tok_seen});
				bus(0, ULC_OFS_CTL, 8'h00);
				check_bit("busy", 1'b1, rd[5]);
			end
		end
		tcyc <= 8'd1;
		wait_idle();
		bus(1, ULC_OFS_ADDR, 8'ha5);
		bus(1, ULC_OFS_TOKEN, 8'h94);
		repeat (12) @(posedge sys_clk);
		check_reg("pre", 32'h1, n_pre);
		check_reg("cmd", 32'h244b, {18'h0, tok_seen});
		wait_idle();
		bus(1, ULC_OFS_CTL, 8'h08);
		check_bit("sof", 1'b0, sof);
		give_verdict();
	end
endmodule : test_usb_link_control_and_address
